// *** src/pief_pkg.sv ***
package pief_pkg;
  localparam int unsigned PIEF_DW = 32;
  localparam int unsigned PIEF_AW = 12;
  localparam int unsigned PIEF_NSRC = 8;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] PIEF_IDX_FLAGS = 8'h0C;
  localparam logic [7:0] PIEF_IDX_ENABLES = 8'h8C;
  localparam logic [7:0] PIEF_IDX_CTRL = 8'h0B;
  localparam logic [7:0] PIEF_IDX_ISTAT = 8'hA0;
  localparam logic [7:0] PIEF_IDX_ICLR = 8'hA1;
  localparam logic [7:0] PIEF_IDX_IEN = 8'hA2;
  // bit positions shared by flag and enable registers; the last two are control register bits
  localparam int unsigned PIEF_B_TMR1 = 0;
  localparam int unsigned PIEF_B_TMR2 = 1;
  localparam int unsigned PIEF_B_CCP1 = 2;
  localparam int unsigned PIEF_B_SSP = 3;
  localparam int unsigned PIEF_B_TX = 4;
  localparam int unsigned PIEF_B_RX = 5;
  localparam int unsigned PIEF_B_ADC = 6;
  localparam int unsigned PIEF_B_PAR = 7;
  localparam int unsigned PIEF_B_GIE = 7;
  localparam int unsigned PIEF_B_PERIPHERAL_GROUP_ENABLE = 6;
  localparam logic [7:0] PIEF_FLAGS_RST = 8'h00;
  localparam logic [7:0] PIEF_ENABLES_RST = 8'h00;
  localparam logic [7:0] PIEF_CTRL_RST = 8'h00;
  // software-writable flag bits; serial flags are hardware owned
  localparam logic [7:0] PIEF_FLAG_WMASK = 8'hCF;
  localparam logic [1:0] PIEF_ISRC_W = 2'h0;

  typedef struct packed {
    logic parallel_port;
    logic converter;
    logic serial_rx_full;
    logic serial_tx_empty;
    logic sync_serial;
    logic capcomp1;
    logic timer2_match;
    logic timer1_overflow;
  } pief_src_s;

  typedef struct packed {
    logic paddr_ok;
    logic [7:0] idx;
  } pief_dec_s;
endpackage

// *** src/pief_apb_slave.sv ***
`timescale 1ns/100ps
module pief_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [pief_pkg::PIEF_AW-1:0] paddr,
  output logic pready,
  output logic pslverr,
  output logic wr_stb,
  output logic rd_stb,
  output pief_pkg::pief_dec_s dec
);
  import pief_pkg::*;
  // zero wait states: the access phase completes in its first cycle
  assign pready = 1'b1;
  assign dec.paddr_ok = (paddr[1:0] == 2'h0);
  assign dec.idx = paddr[9:2];
  logic acc;
  logic hit_r;
  logic hit_w;
  logic mapped;
  assign acc = psel & penable;
  assign wr_stb = acc & hit_w;
  assign rd_stb = acc & hit_r;
  always_comb begin
    mapped = 1'b0;
    if (paddr[PIEF_AW-1:10] != '0 || !dec.paddr_ok) begin
      mapped = 1'b0;
    end else if (dec.idx == PIEF_IDX_FLAGS) begin
      mapped = 1'b1;
    end else if (dec.idx == PIEF_IDX_ENABLES) begin
      mapped = 1'b1;
    end else if (dec.idx == PIEF_IDX_CTRL) begin
      mapped = 1'b1;
    end else if (dec.idx == PIEF_IDX_ISTAT) begin
      mapped = 1'b1;
    end else if (dec.idx == PIEF_IDX_ICLR) begin
      mapped = 1'b1;
    end else if (dec.idx == PIEF_IDX_IEN) begin
      mapped = 1'b1;
    end
  end
  assign hit_r = mapped;
  assign hit_w = mapped;
  assign pslverr = acc & ~mapped;
endmodule

// *** src/pief_top.sv ***
// Our own choice: register access over APB.
`timescale 1ns/100ps
// Behaviour
// - eight-bit enable register at index 8Ch, one bit per source
// - parallel port enable bit gates parallel port interrupt
// - converter enable bit gates conversion-complete interrupt
// - serial receive enable bit gates receive interrupt
// - serial transmit enable bit gates transmit interrupt
// - timer-2 match enable bit gates period match interrupt
// - timer-1 overflow enable bit gates overflow interrupt
// - nothing forwarded unless group enable, control bit 6, is set
// - flags set on their condition regardless of any enable
// - eight-bit flag register at index 0Ch, same bit layout
// - parallel port flag sets on external access, software clears it
// - receive flag shows buffer full, cleared by data register read
// - transmit flag shows buffer empty, cleared by data register write
// - converter flag sets on conversion done, stays until cleared
module pief_top #(
  parameter int unsigned NSRC = pief_pkg::PIEF_NSRC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pief_pkg::PIEF_AW-1:0] paddr,
  input wire logic [pief_pkg::PIEF_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pief_pkg::PIEF_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pief_pkg::pief_src_s src_event,
  input wire logic serial_rx_full,
  input wire logic serial_tx_empty,
  output logic periph_irq,
  output logic irq
);
  import pief_pkg::*;

  if (NSRC != 8) begin : g_chk
    $error("pief_top serves exactly eight sources");
  end

  logic wr_stb;
  logic rd_stb;
  pief_dec_s dec;
  logic [7:0] flags_q;
  logic [7:0] enables_q;
  logic [7:0] ctrl_q;
  logic [1:0] istat_q;
  logic [1:0] ien_q;
  logic [7:0] ev;
  logic [7:0] wbyte;
  logic lane0;
  logic wr_flags;
  logic wr_en;
  logic wr_ctrl;
  logic wr_iclr;
  logic wr_ien;
  logic periph_irq_d;
  logic periph_irq_q;
  logic [1:0] iev;

  pief_apb_slave u_bus (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .dec(dec)
  );

  assign wbyte = pwdata[7:0];
  assign lane0 = pstrb[0];
  assign wr_flags = wr_stb & pwrite & lane0 & (dec.idx == PIEF_IDX_FLAGS);
  assign wr_en = wr_stb & pwrite & lane0 & (dec.idx == PIEF_IDX_ENABLES);
  assign wr_ctrl = wr_stb & pwrite & lane0 & (dec.idx == PIEF_IDX_CTRL);
  assign wr_iclr = wr_stb & pwrite & lane0 & (dec.idx == PIEF_IDX_ICLR);
  assign wr_ien = wr_stb & pwrite & lane0 & (dec.idx == PIEF_IDX_IEN);

  // event vector in register bit order
  assign ev = src_event;

  // enable register; sync serial and capcomp gate alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enables_q <= PIEF_ENABLES_RST;
    end else if (wr_en) begin
      enables_q <= wbyte;
    end
  end

  // global control: only the two enables this block uses are kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= PIEF_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wbyte & 8'hC0;
    end
  end

  // flags: set wins over a software clear in the same cycle
  genvar gi;
  for (gi = 0; gi < 8; gi++) begin : g_flag
    if (gi == PIEF_B_RX) begin : g_rx
      // level mirror of the buffer; a data read drains it upstream
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_q[gi] <= 1'b0;
        end else begin
          flags_q[gi] <= serial_rx_full;
        end
      end
    end else if (gi == PIEF_B_TX) begin : g_tx
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_q[gi] <= 1'b0;
        end else begin
          flags_q[gi] <= serial_tx_empty;
        end
      end
    end else begin : g_sw
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_q[gi] <= 1'b0;
        end else if (ev[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (wr_flags) begin
          flags_q[gi] <= wbyte[gi];
        end
      end
    end
  end

  // request: each enable bit gates its own flag, then group and global
  always_comb begin
    periph_irq_d = (|(flags_q & enables_q))
      & ctrl_q[PIEF_B_PERIPHERAL_GROUP_ENABLE]
      & ctrl_q[PIEF_B_GIE];
  end

  // registered so the request is a clean level; costs one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_q <= 1'b0;
    end else begin
      periph_irq_q <= periph_irq_d;
    end
  end
  assign periph_irq = periph_irq_q;

  // block interrupt status: bit0 request rose, bit1 bus error
  assign iev[0] = periph_irq_d & ~periph_irq_q;
  assign iev[1] = pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= PIEF_ISRC_W;
    end else begin
      istat_q <= iev | (istat_q & ~({2{wr_iclr}} & wbyte[1:0]));
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= PIEF_ISRC_W;
    end else if (wr_ien) begin
      ien_q <= wbyte[1:0];
    end
  end
  assign irq = |(istat_q & ien_q);

  // read data, driven to the bus through a combinational select, not registered
  always_comb begin
    prdata = '0;
    if (rd_stb && !pwrite) begin
      if (dec.idx == PIEF_IDX_FLAGS) begin
        prdata[7:0] = flags_q;
      end else if (dec.idx == PIEF_IDX_ENABLES) begin
        prdata[7:0] = enables_q;
      end else if (dec.idx == PIEF_IDX_CTRL) begin
        prdata[7:0] = ctrl_q;
      end else if (dec.idx == PIEF_IDX_ISTAT) begin
        prdata[1:0] = istat_q;
      end else if (dec.idx == PIEF_IDX_IEN) begin
        prdata[1:0] = ien_q;
      end
    end
  end

  // note: a stale flag fires as soon as its enable is written
  // are software duties; hardware does not mask them

  a_irq_needs_group: assert property (
    @(posedge pclk) disable iff (!presetn)
    periph_irq |-> $past(ctrl_q[PIEF_B_PERIPHERAL_GROUP_ENABLE]))
    else $error("request without group enable");
  a_irq_needs_global: assert property (
    @(posedge pclk) disable iff (!presetn)
    periph_irq |-> $past(ctrl_q[PIEF_B_GIE]))
    else $error("request without global enable");
  a_irq_follows_and: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 (periph_irq == $past(|(flags_q & enables_q)
      & ctrl_q[PIEF_B_GIE] & ctrl_q[PIEF_B_PERIPHERAL_GROUP_ENABLE])))
    else $error("request does not follow flags and enables");
  a_irq_drops: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q[PIEF_B_PERIPHERAL_GROUP_ENABLE] |=> !periph_irq)
    else $error("request kept with group enable clear");
  a_flag_sets_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    ev[PIEF_B_ADC] |=> flags_q[PIEF_B_ADC])
    else $error("converter flag missed its event");
  a_par_flag_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    ev[PIEF_B_PAR] |=> flags_q[PIEF_B_PAR])
    else $error("parallel flag missed its event");
  a_rx_flag_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    serial_rx_full |=> flags_q[PIEF_B_RX])
    else $error("receive flag not following buffer");
  a_tx_flag_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    !serial_tx_empty |=> !flags_q[PIEF_B_TX])
    else $error("transmit flag not following buffer");
  a_serial_ro: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_flags && wbyte[PIEF_B_RX] && !serial_rx_full)
    |=> !flags_q[PIEF_B_RX])
    else $error("software wrote the receive flag");
  a_flag_no_enable: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ev[PIEF_B_TMR1] && !enables_q[PIEF_B_TMR1]) |=> flags_q[PIEF_B_TMR1])
    else $error("flag gated by enable");
  a_enable_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en |=> enables_q == $past(wbyte))
    else $error("enable register not written");
  a_strobe_needed: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_stb && pwrite && !lane0) |=> $stable(enables_q))
    else $error("write without byte lane landed");
  a_err_no_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pslverr && pwrite) |=> $stable(enables_q))
    else $error("errored write changed the enables");
  a_flag_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_flags && !wbyte[PIEF_B_TMR2] && !ev[PIEF_B_TMR2])
    |=> !flags_q[PIEF_B_TMR2])
    else $error("flag not cleared by write");
  a_blocked_source: assert property (
    @(posedge pclk) disable iff (!presetn)
    (enables_q == 8'h00) [*2] |=> !periph_irq)
    else $error("request with all enables clear");
  a_ctrl_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ctrl_q == ($past(wbyte) & 8'hC0))
    else $error("control register not written");
  a_read_flags: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_stb && !pwrite && dec.idx == PIEF_IDX_FLAGS)
    |-> prdata == {24'h00_0000, flags_q})
    else $error("flag read returned wrong data");
  a_read_enables: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_stb && !pwrite && dec.idx == PIEF_IDX_ENABLES)
    |-> prdata == {24'h00_0000, enables_q})
    else $error("enable read returned wrong data");
  a_read_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !rd_stb |-> prdata == '0)
    else $error("read data outside a read");
  a_ien_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ien |=> ien_q == $past(wbyte[1:0]))
    else $error("interrupt enable not written");
  a_istat_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    (istat_q[0] && !(wr_iclr && wbyte[0])) |=> istat_q[0])
    else $error("status bit dropped without a clear");
  a_iclr_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_iclr && wbyte[0] && !iev[0]) |=> !istat_q[0])
    else $error("status bit not cleared");

  // per-bit checks; serial bits follow their buffers, the rest are sticky
  genvar ga;
  for (ga = 0; ga < 8; ga++) begin : g_bit_chk
    if (ga == PIEF_B_RX) begin : g_rx_chk
      a_rx_mirror: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 (flags_q[ga] == $past(serial_rx_full)))
        else $error("receive flag does not mirror buffer");
    end else if (ga == PIEF_B_TX) begin : g_tx_chk
      a_tx_mirror: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 (flags_q[ga] == $past(serial_tx_empty)))
        else $error("transmit flag does not mirror buffer");
    end else begin : g_sw_chk
      a_bit_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        ev[ga] |=> flags_q[ga])
        else $error("flag missed its event");
      a_bit_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        (flags_q[ga] && !wr_flags) |=> flags_q[ga])
        else $error("flag dropped without a write");
      a_bit_written: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_flags && !ev[ga]) |=> flags_q[ga] == $past(wbyte[ga]))
        else $error("flag write did not land");
      a_bit_no_self: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!flags_q[ga] && !ev[ga] && !wr_flags) |=> !flags_q[ga])
        else $error("flag set without its event");
    end
    a_en_bit_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_en |=> enables_q[ga] == $past(wbyte[ga]))
      else $error("enable bit not written");
    a_bit_gates: assert property (
      @(posedge pclk) disable iff (!presetn)
      (flags_q[ga] && enables_q[ga] && ctrl_q[PIEF_B_GIE]
      && ctrl_q[PIEF_B_PERIPHERAL_GROUP_ENABLE]) |=> periph_irq)
      else $error("enabled flag did not request");
    a_bit_blocked: assert property (
      @(posedge pclk) disable iff (!presetn)
      (flags_q == 8'(1 << ga) && !enables_q[ga]) |=> !periph_irq)
      else $error("disabled flag raised a request");
  end

  c_irq_raise: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(periph_irq));
  c_set_and_clear: cover property (@(posedge pclk) disable iff (!presetn)
    ev[PIEF_B_ADC] && wr_flags);
  c_block_irq: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq));
  c_serial_flag: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(flags_q[PIEF_B_RX]));
endmodule

// *** sim/tb_peripheral_irq_enable_flag_bank.sv ***
`timescale 1ns/100ps
module tb_peripheral_irq_enable_flag_bank;
  import pief_pkg::*;
  localparam logic [11:0] A_FLG = 12'h030;
  localparam logic [11:0] A_ENA = 12'h230;
  localparam logic [11:0] A_CTL = 12'h02C;
  localparam logic [11:0] A_IST = 12'h280;
  localparam logic [11:0] A_ICL = 12'h284;
  localparam logic [11:0] A_IEN = 12'h288;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, periph_irq, irq;
  logic [7:0] src_event = 8'h00;
  logic serial_rx_full = 1'b0, serial_tx_empty = 1'b0;
  logic [31:0] rd;
  logic er;
  int fails = 0, check_count = 0, cyc = 0;

  always #5 pclk = ~pclk;

  pief_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(pief_src_s'(src_event)), .serial_rx_full(serial_rx_full),
    .serial_tx_empty(serial_tx_empty), .periph_irq(periph_irq), .irq(irq));

  task automatic give_verdict();
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until the edge where pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // flag lands one edge after the event, irq output one edge later
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge pclk);
    src_event <= v;
    @(posedge pclk);
    src_event <= 8'h00;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_FLG, 8'h00); chk(rd, 32'h0000_0000);
    apb(1'b0, A_ENA, 8'h00); chk(rd, 32'h0000_0000);
    chk(pready, 1'b1);
    apb(1'b1, A_ENA, 8'hA5);
    apb(1'b0, A_ENA, 8'h00); chk(rd, 32'h0000_00A5);
    apb(1'b1, A_ENA, 8'h00);
    pulse(8'hCF);
    settle();
    apb(1'b0, A_FLG, 8'h00); chk(rd, 32'h0000_00CF);
    chk(periph_irq, 1'b0);
    apb(1'b1, A_FLG, 8'h00);
    apb(1'b1, A_FLG, 8'hFF);
    apb(1'b0, A_FLG, 8'h00); chk(rd, 32'h0000_00CF);
    for (int b = 0; b < 8; b++) begin
      apb(1'b1, A_FLG, 8'h00);
      apb(1'b1, A_CTL, 8'hC0);
      apb(1'b1, A_ENA, 8'(1 << b));
      settle();
      chk(periph_irq, 1'b0);
      if (b == 5) serial_rx_full <= 1'b1;
      else if (b == 4) serial_tx_empty <= 1'b1;
      else pulse(8'(1 << b));
      settle();
      chk(periph_irq, 1'b1);
      apb(1'b1, A_CTL, 8'h80);
      settle();
      chk(periph_irq, 1'b0);
      apb(1'b1, A_CTL, 8'hC0);
      apb(1'b1, A_ENA, 8'h00);
      settle();
      chk(periph_irq, 1'b0);
      // serial flags survive a software clear, the rest drop
      apb(1'b1, A_FLG, 8'h00);
      apb(1'b0, A_FLG, 8'h00);
      chk(rd, (b == 4 || b == 5) ? 32'(1 << b) : 32'h0);
      serial_rx_full <= 1'b0;
      serial_tx_empty <= 1'b0;
      settle();
      apb(1'b0, A_FLG, 8'h00); chk(rd, 32'h0000_0000);
    end
    apb(1'b1, A_ENA, 8'h01);
    apb(1'b1, A_IEN, 8'h01);
    pulse(8'h01);
    settle();
    chk(irq, 1'b1);
    apb(1'b0, A_IST, 8'h00); chk(rd, 32'h0000_0001);
    apb(1'b1, A_IEN, 8'h00);
    #1 chk(irq, 1'b0);
    apb(1'b1, A_FLG, 8'h00);
    apb(1'b1, A_IEN, 8'h01);
    apb(1'b1, A_ICL, 8'h01);
    apb(1'b0, A_IST, 8'h00); chk(rd, 32'h0000_0000);
    chk(irq, 1'b0);
    apb(1'b0, 12'h100, 8'h00); chk({er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, A_IEN, 8'h02);
    #1 chk(irq, 1'b1);
    apb(1'b1, A_ICL, 8'h02);
    #1 chk(irq, 1'b0);
    give_verdict();
  end
endmodule
